// file: shared/synth_serial_pkg.sv
// constants, field layouts and carrier types of the synthesizer serial register bank
package synth_serial_pkg;

    localparam int REG_W     = 12;
    localparam int ADDR_W    = 4;
    localparam int NUM_REGS  = 10;
    localparam int FRAME_W   = 16;
    localparam int CNT_W     = 5;
    localparam int DIV_W     = 9;
    localparam int MAIN_HI_W = 10;
    localparam int MAIN_LO_W = 8;
    localparam int AUX_FR_W  = 10;
    localparam int DVD_W     = 18;
    localparam int MAG_W     = 4;
    localparam int OFS_W     = 28;

    // register addresses
    localparam logic [3:0] ADDR_MAIN_DIV   = 4'h0;
    localparam logic [3:0] ADDR_MAIN_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_MAIN_LOW   = 4'h2;
    localparam logic [3:0] ADDR_AUX_DIV    = 4'h3;
    localparam logic [3:0] ADDR_AUX_FRAC   = 4'h4;
    localparam logic [3:0] ADDR_REF_DIV    = 4'h5;
    localparam logic [3:0] ADDR_PUMP_CTRL  = 4'h6;
    localparam logic [3:0] ADDR_PWR_SEL    = 4'h7;
    localparam logic [3:0] ADDR_MOD_CTRL   = 4'h8;
    localparam logic [3:0] ADDR_MOD_SAMPLE = 4'h9;
    localparam logic [3:0] ADDR_LAST       = 4'h9;

    // reset values
    localparam logic [11:0] RESET_DIVIDER = 12'h006;
    localparam logic [11:0] RESET_OTHER   = 12'h000;
    localparam logic [8:0]  RESET_DIV_IDX = 9'h006;

    // serial frame lengths in clock cycles
    localparam logic [4:0] CNT_SHORT_MIN = 5'h02;
    localparam logic [4:0] CNT_SHORT_MAX = 5'h0C;
    localparam logic [4:0] CNT_FULL      = 5'h10;
    localparam logic [4:0] CNT_SAT       = 5'h1F;
    localparam logic [4:0] CNT_ONE       = 5'h01;
    localparam logic [4:0] CNT_ZERO      = 5'h00;

    // field positions
    localparam int MOD_SEL_BIT = 0;
    localparam int MAG_LSB     = 1;
    localparam int MODE18_BIT  = 10;
    localparam int INTMODE_BIT = 11;

    typedef struct packed {
        logic [DIV_W-1:0] divider;
        logic [DVD_W-1:0] dividend;
    } ratio_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  data;
    } frame_word_t;

    typedef enum logic {
        MOD_IDLE    = 1'b0,
        MOD_PENDING = 1'b1
    } mod_state_t;

endpackage

// file: core/synth_serial_register_load.sv
// serial-programmed register bank with divide-ratio update and modulation sample path
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - host writes aux divider before aux dividend
// RULE_02 - fractional mode: aux ratio applies on dividend write
// RULE_03 - integer mode: divider write applies ratio at once
// RULE_04 - sixteen-cycle strobe is a normal addressed write
// RULE_05 - sample forwarded on next divided vco fall
// RULE_06 - 2 to 12 cycle strobe loads sample
// RULE_07 - short strobe data defaults to data pin
// RULE_08 - serial bits resynchronized to reference clock
// RULE_09 - control bit selects alternate modulation pin
// RULE_10 - second host may feed samples on alternate pin
// RULE_11 - ten write-only registers, 4-bit address, 12-bit data
// RULE_12 - 2 to 12 bit transfers carry no address
// RULE_13 - sample length sets number of frequency steps
// RULE_14 - magnitude field shifts sample left by m
// RULE_15 - sample offset adds to main channel dividend
// RULE_16 - host keeps dividend plus sample within 0.5625
// RULE_17 - strobe ending before thirteenth edge is sample
// RULE_18 - long strobe uses only final sixteen bits
// RULE_19 - main ratio applies on dividend high write
// RULE_20 - reset clears registers, addresses 0 and 3 to 0x006
// RULE_21 - strobe under two cycles changes nothing
module synth_serial_register_load (
    // reference clock domain
    input  wire logic                                 clk,
    input  wire logic                                 rst_b,
    // serial link, clocked by the host
    input  wire logic                                 sclk,
    input  wire logic                                 cs_b,
    input  wire logic                                 sdata,
    input  wire logic                                 mod_in,
    // divided main vco from the main divider
    input  wire logic                                 divided_main_vco_edge,
    // applied divide ratios
    output synth_serial_pkg::ratio_t                  main_ratio,
    output synth_serial_pkg::ratio_t                  aux_ratio,
    // general configuration words
    output logic [synth_serial_pkg::REG_W-1:0]        reference_dividers,
    output logic [synth_serial_pkg::REG_W-1:0]        detector_pump_control,
    output logic [synth_serial_pkg::REG_W-1:0]        powerdown_output_select,
    // modulation unit
    output logic [synth_serial_pkg::REG_W-1:0]        modulation_applied,
    output logic signed [synth_serial_pkg::OFS_W-1:0] carrier_offset
);

    ////////////////////////////////////////////////////////////////////////////
    // link side: shift and count on the host clock

    logic                                 in_frame;
    logic                                 frame_clr_b;
    logic [synth_serial_pkg::CNT_W-1:0]   bit_count;
    logic [synth_serial_pkg::FRAME_W-1:0] data_shift;
    logic [synth_serial_pkg::REG_W-1:0]   mod_shift;

    // the host clock stops between frames, so the frame start is seen as
    // the first edge after chip select cleared this flag
    assign frame_clr_b = rst_b & ~cs_b;

    always_ff @(posedge sclk or negedge frame_clr_b) begin
        if (!frame_clr_b) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_count <= synth_serial_pkg::CNT_ZERO;
        end else if (!cs_b) begin
            if (!in_frame) begin
                bit_count <= synth_serial_pkg::CNT_ONE;
            end else if (bit_count != synth_serial_pkg::CNT_SAT) begin
                bit_count <= bit_count + synth_serial_pkg::CNT_ONE;
            end
        end
    end

    // both pins shift together; the choice between them is made later
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            data_shift <= '0;
            mod_shift  <= '0;
        end else if (!cs_b) begin
            data_shift <= {data_shift[synth_serial_pkg::FRAME_W-2:0], sdata}; // RULE_18
            mod_shift  <= {mod_shift[synth_serial_pkg::REG_W-2:0], mod_in};   // RULE_10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame end crossing into the reference clock

    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic frame_end;

    // count and shift words are frozen once chip select is high, so they
    // are sampled only after the synchronised rise; the host must hold
    // chip select high for at least four reference cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d  <= 1'b1;
        end else begin
            cs_s1 <= cs_b;  // RULE_08
            cs_s2 <= cs_s1; // RULE_08
            cs_d  <= cs_s2;
        end
    end

    assign frame_end = cs_s2 & ~cs_d;

    ////////////////////////////////////////////////////////////////////////////
    // frame decode

    logic [synth_serial_pkg::REG_W-1:0]  regs [synth_serial_pkg::NUM_REGS];
    logic                                int_mode;
    logic                                mode18;
    logic                                mod_sel;
    logic [synth_serial_pkg::MAG_W-1:0]  magnitude;
    logic                                short_ok;
    logic                                full_ok;
    logic [synth_serial_pkg::REG_W-1:0]  short_src;
    logic [synth_serial_pkg::REG_W-1:0]  short_word;
    logic [synth_serial_pkg::MAG_W-1:0]  pad;
    synth_serial_pkg::frame_word_t       full_word;
    logic                                wr_en;
    logic [synth_serial_pkg::ADDR_W-1:0] wr_addr;
    logic [synth_serial_pkg::REG_W-1:0]  wr_data;

    assign int_mode  = regs[synth_serial_pkg::ADDR_PWR_SEL][synth_serial_pkg::INTMODE_BIT];
    assign mode18    = regs[synth_serial_pkg::ADDR_PWR_SEL][synth_serial_pkg::MODE18_BIT];
    assign mod_sel   = regs[synth_serial_pkg::ADDR_MOD_CTRL][synth_serial_pkg::MOD_SEL_BIT];
    assign magnitude = regs[synth_serial_pkg::ADDR_MOD_CTRL][synth_serial_pkg::MAG_LSB +: synth_serial_pkg::MAG_W];
    assign full_word = data_shift;

    always_comb begin
        short_ok = (bit_count >= synth_serial_pkg::CNT_SHORT_MIN)
                && (bit_count <= synth_serial_pkg::CNT_SHORT_MAX);             // RULE_17
        full_ok  = (bit_count >= synth_serial_pkg::CNT_FULL)
                && (full_word.addr <= synth_serial_pkg::ADDR_LAST);            // RULE_04
        short_src = mod_sel ? mod_shift
                            : data_shift[synth_serial_pkg::REG_W-1:0];          // RULE_07 RULE_09
        // the last n bits sit right aligned; sign-extend them from bit n-1
        pad = synth_serial_pkg::MAG_W'(synth_serial_pkg::CNT_SHORT_MAX - bit_count);
        short_word = synth_serial_pkg::REG_W'($signed(short_src << pad) >>> pad); // RULE_13
        wr_en   = frame_end & (short_ok | full_ok);                             // RULE_21
        wr_addr = short_ok ? synth_serial_pkg::ADDR_MOD_SAMPLE : full_word.addr; // RULE_12
        wr_data = short_ok ? short_word : full_word.data;                       // RULE_06 RULE_11
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file, write only

    genvar g;
    generate
        for (g = 0; g < synth_serial_pkg::NUM_REGS; g++) begin : g_reg
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    regs[g] <= (g == synth_serial_pkg::ADDR_MAIN_DIV || g == synth_serial_pkg::ADDR_AUX_DIV)
                               ? synth_serial_pkg::RESET_DIVIDER : synth_serial_pkg::RESET_OTHER; // RULE_20
                end else if (wr_en && wr_addr == synth_serial_pkg::ADDR_W'(g)) begin
                    regs[g] <= wr_data; // RULE_11
                end
            end
        end
    endgenerate

    assign reference_dividers      = regs[synth_serial_pkg::ADDR_REF_DIV];
    assign detector_pump_control   = regs[synth_serial_pkg::ADDR_PUMP_CTRL];
    assign powerdown_output_select = regs[synth_serial_pkg::ADDR_PWR_SEL];

    ////////////////////////////////////////////////////////////////////////////
    // divide-ratio update

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            main_ratio.divider  <= synth_serial_pkg::RESET_DIV_IDX;
            main_ratio.dividend <= '0;
        end else if (wr_en && int_mode && wr_addr == synth_serial_pkg::ADDR_MAIN_DIV) begin
            main_ratio.divider  <= wr_data[synth_serial_pkg::DIV_W-1:0]; // RULE_03
            main_ratio.dividend <= '0;
        end else if (wr_en && !int_mode && wr_addr == synth_serial_pkg::ADDR_MAIN_HIGH) begin
            main_ratio.divider <= regs[synth_serial_pkg::ADDR_MAIN_DIV][synth_serial_pkg::DIV_W-1:0]; // RULE_19
            if (mode18) begin
                main_ratio.dividend <= {wr_data[synth_serial_pkg::MAIN_HI_W-1:0],
                    regs[synth_serial_pkg::ADDR_MAIN_LOW][synth_serial_pkg::MAIN_LO_W-1:0]};
            end else begin
                main_ratio.dividend <= synth_serial_pkg::DVD_W'($signed(wr_data[synth_serial_pkg::MAIN_HI_W-1:0]));
            end
        end
    end

    // in fractional mode a divider write alone leaves the running ratio alone
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aux_ratio.divider  <= synth_serial_pkg::RESET_DIV_IDX;
            aux_ratio.dividend <= '0;
        end else if (wr_en && int_mode && wr_addr == synth_serial_pkg::ADDR_AUX_DIV) begin
            aux_ratio.divider  <= wr_data[synth_serial_pkg::DIV_W-1:0]; // RULE_03
            aux_ratio.dividend <= '0;
        end else if (wr_en && !int_mode && wr_addr == synth_serial_pkg::ADDR_AUX_FRAC) begin
            aux_ratio.divider  <= regs[synth_serial_pkg::ADDR_AUX_DIV][synth_serial_pkg::DIV_W-1:0]; // RULE_02
            aux_ratio.dividend <= synth_serial_pkg::DVD_W'($signed(wr_data[synth_serial_pkg::AUX_FR_W-1:0]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modulation sample forwarding on the divided vco

    logic                         vco_s1;
    logic                         vco_s2;
    logic                         vco_d;
    logic                         vco_fall;
    logic                         sample_load;
    synth_serial_pkg::mod_state_t mod_state;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vco_s1 <= 1'b0;
            vco_s2 <= 1'b0;
            vco_d  <= 1'b0;
        end else begin
            vco_s1 <= divided_main_vco_edge;
            vco_s2 <= vco_s1;
            vco_d  <= vco_s2;
        end
    end

    assign vco_fall    = vco_d & ~vco_s2;
    assign sample_load = wr_en && wr_addr == synth_serial_pkg::ADDR_MOD_SAMPLE;

    // a load in the cycle of the forwarding edge keeps the request pending,
    // so the newer sample goes out on the following edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_state          <= synth_serial_pkg::MOD_IDLE;
            modulation_applied <= '0;
        end else begin
            case (mod_state)
                synth_serial_pkg::MOD_IDLE: begin
                    if (sample_load) begin
                        mod_state <= synth_serial_pkg::MOD_PENDING;
                    end
                end
                synth_serial_pkg::MOD_PENDING: begin
                    if (vco_fall) begin
                        modulation_applied <= regs[synth_serial_pkg::ADDR_MOD_SAMPLE]; // RULE_05
                        mod_state <= sample_load ? synth_serial_pkg::MOD_PENDING : synth_serial_pkg::MOD_IDLE;
                    end
                end
                default: begin
                    mod_state <= synth_serial_pkg::MOD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instantaneous carrier offset

    logic signed [synth_serial_pkg::OFS_W-1:0] dividend_ext;
    logic signed [synth_serial_pkg::OFS_W-1:0] sample_ext;
    logic signed [synth_serial_pkg::OFS_W-1:0] next_carrier_offset;

    // no range check here: keeping the sum inside the modulator span is the host's job
    always_comb begin
        dividend_ext        = synth_serial_pkg::OFS_W'($signed(main_ratio.dividend));
        sample_ext          = synth_serial_pkg::OFS_W'($signed(modulation_applied));
        next_carrier_offset = dividend_ext + (sample_ext <<< magnitude); // RULE_14 RULE_15
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            carrier_offset <= '0;
        end else begin
            carrier_offset <= next_carrier_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_short_load: assert property ( // RULE_06
        frame_end && short_ok |=> regs[synth_serial_pkg::ADDR_MOD_SAMPLE] == $past(short_word))
        else $error("short strobe did not load the sample register");

    chk_full_write: assert property ( // RULE_04
        frame_end && bit_count >= synth_serial_pkg::CNT_FULL && full_word.addr == synth_serial_pkg::ADDR_MOD_SAMPLE
        |=> regs[synth_serial_pkg::ADDR_MOD_SAMPLE] == $past(data_shift[synth_serial_pkg::REG_W-1:0]))
        else $error("addressed write lost its data");

    chk_tiny_ignore: assert property ( // RULE_21
        frame_end && bit_count < synth_serial_pkg::CNT_SHORT_MIN
        |=> $stable(regs[synth_serial_pkg::ADDR_MOD_SAMPLE]) && $stable(regs[synth_serial_pkg::ADDR_MAIN_DIV]))
        else $error("strobe under two cycles changed a register");

    chk_aux_hold: assert property ( // RULE_02
        wr_en && !int_mode && wr_addr == synth_serial_pkg::ADDR_AUX_DIV |=> $stable(aux_ratio))
        else $error("aux ratio moved on divider write in fractional mode");

    chk_aux_apply: assert property ( // RULE_02
        wr_en && !int_mode && wr_addr == synth_serial_pkg::ADDR_AUX_FRAC
        |=> aux_ratio.divider == $past(regs[synth_serial_pkg::ADDR_AUX_DIV][synth_serial_pkg::DIV_W-1:0]))
        else $error("aux ratio not applied on dividend write");

    chk_int_apply: assert property ( // RULE_03
        wr_en && int_mode && wr_addr == synth_serial_pkg::ADDR_MAIN_DIV
        |=> main_ratio.divider == $past(wr_data[synth_serial_pkg::DIV_W-1:0]))
        else $error("integer mode divider not applied at once");

    chk_main_apply: assert property ( // RULE_19
        wr_en && !int_mode && !mode18 && wr_addr == synth_serial_pkg::ADDR_MAIN_HIGH
        |=> main_ratio.dividend[synth_serial_pkg::MAIN_HI_W-1:0] == $past(wr_data[synth_serial_pkg::MAIN_HI_W-1:0]))
        else $error("main ratio not applied on high part write");

    chk_mod_forward: assert property ( // RULE_05
        mod_state == synth_serial_pkg::MOD_PENDING && vco_fall
        |=> modulation_applied == $past(regs[synth_serial_pkg::ADDR_MOD_SAMPLE]))
        else $error("sample not forwarded on divided vco fall");

    chk_mod_wait: assert property ( // RULE_05
        !vco_fall |=> $stable(modulation_applied))
        else $error("sample forwarded without a divided vco fall");

    chk_source_pin: assert property ( // RULE_09
        frame_end && short_ok && mod_sel |=> regs[synth_serial_pkg::ADDR_MOD_SAMPLE][0] == $past(mod_shift[0]))
        else $error("alternate modulation pin not selected");

    chk_offset_sum: assert property ( // RULE_14
        $stable(modulation_applied) && $stable(main_ratio) && $stable(magnitude)
        |-> carrier_offset == dividend_ext + (sample_ext <<< magnitude))
        else $error("carrier offset does not match dividend plus shifted sample");

    cov_short_data:  cover property (frame_end && short_ok && !mod_sel);
    cov_short_alt:   cover property (frame_end && short_ok && mod_sel);
    cov_full_write:  cover property (frame_end && full_ok);
    cov_mod_forward: cover property (mod_state == synth_serial_pkg::MOD_PENDING && vco_fall);

endmodule

// file: tb/serial_host.sv
// host-side model driving the three-wire programming link and the alternate modulation pin
`timescale 1ns/1ps
module serial_host (
    // serial link
    output logic sclk,
    output logic cs_b,
    output logic sdata,
    output logic mod_in
);
    initial begin
        sclk   = 1'b0;
        cs_b   = 1'b1;
        sdata  = 1'b0;
        mod_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame of n bits, msb first, 32 ns link clock that stands still between frames
    // the pin not carrying data toggles every bit so a wrong source pick shows up
    task automatic send(input logic [31:0] bits, input int n, input logic on_mod);
        cs_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdata  = on_mod ? ~sdata : bits[i];
            mod_in = on_mod ? bits[i] : ~mod_in;
            #8;
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
            #8;
        end
        cs_b   = 1'b1;
        // released lines show the inverse, not the last bit
        sdata  = ~sdata;
        mod_in = ~mod_in;
        // chip select stays high well beyond four reference cycles
        #40;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the serial register bank
`timescale 1ns/1ps
module testbench;
    logic                     clk;
    logic                     rst_b;
    logic                     sclk;
    logic                     cs_b;
    logic                     sdata;
    logic                     mod_in;
    logic                     vco;
    synth_serial_pkg::ratio_t main_ratio;
    synth_serial_pkg::ratio_t aux_ratio;
    logic [11:0]              ref_div;
    logic [11:0]              pump;
    logic [11:0]              pwr;
    logic [11:0]              applied;
    logic signed [27:0]       offset;
    logic signed [17:0]       exp_dvd;
    int                       fails;
    int                       tests_run;
    int                       cycles;

    synth_serial_register_load i_synth_serial_register_load (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdata(sdata), .mod_in(mod_in),
        .divided_main_vco_edge(vco), .main_ratio(main_ratio), .aux_ratio(aux_ratio),
        .reference_dividers(ref_div), .detector_pump_control(pump), .powerdown_output_select(pwr),
        .modulation_applied(applied), .carrier_offset(offset)
    );
    serial_host i_serial_host (.sclk(sclk), .cs_b(cs_b), .sdata(sdata), .mod_in(mod_in));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // about 2200 cycles are needed; the margin covers slow frames
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] exp_ofs(input logic [11:0] s, input int m);
        logic signed [27:0] a;
        logic signed [27:0] b;
        a = exp_dvd;
        b = signed'(s);
        b = b <<< m;
        return {4'h0, a + b};
    endfunction

    task automatic wr(input logic [3:0] addr, input logic [11:0] data);
        i_serial_host.send({16'h0, addr, data}, 16, 1'b0);
    endtask

    // a falling divided vco edge; settle time covers sync plus the offset stage
    task automatic vco_fall();
        @(negedge clk);
        vco = 1'b0;
        repeat (6) @(negedge clk);
        vco = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("main", 32'(main_ratio), {5'h0, 9'h006, 18'h0});
        check("aux", 32'(aux_ratio), {5'h0, 9'h006, 18'h0});
        check("cfg", {ref_div, pump, pwr[7:0]}, 32'h0);
        check("applied", 32'(applied), 32'h0);
        check("offset", {4'h0, offset}, 32'h0);
    endtask

    task automatic t_main_frac();
        wr(4'h7, 12'h400);
        wr(4'h0, 12'h00D);
        wr(4'h2, 12'h098);
        check("main early", 32'(main_ratio), {5'h0, 9'h006, 18'h0});
        wr(4'h1, 12'h07D);
        exp_dvd = 18'h07D98;
        check("main", 32'(main_ratio), {5'h0, 9'h00D, 18'h07D98});
        check("pwr", 32'(pwr), 32'h400);
    endtask

    task automatic t_aux_frac();
        wr(4'h3, 12'h012);
        check("aux early", 32'(aux_ratio), {5'h0, 9'h006, 18'h0});
        wr(4'h4, 12'h334);
        check("aux", 32'(aux_ratio), {5'h0, 9'h012, 18'h3FF34});
    endtask

    task automatic t_addr_mod();
        wr(4'h9, 12'hABC);
        check("applied early", 32'(applied), 32'h0);
        vco_fall();
        check("applied", 32'(applied), 32'hABC);
        check("offset", {4'h0, offset}, exp_ofs(12'hABC, 0));
    endtask

    task automatic t_short();
        int          lens[3];
        logic [11:0] vals[3];
        logic [11:0] exps[3];
        lens = '{2, 7, 12};
        vals = '{12'h002, 12'h015, 12'h5A3};
        exps = '{12'hFFE, 12'h015, 12'h5A3};
        for (int k = 0; k < 3; k++) begin
            i_serial_host.send({20'h0, vals[k]}, lens[k], 1'b0);
            vco_fall();
            check("short", 32'(applied), 32'(exps[k]));
        end
    endtask

    task automatic t_refuse();
        i_serial_host.send(32'h1, 1, 1'b0);
        i_serial_host.send(32'h3FFF, 14, 1'b0);
        wr(4'hA, 12'hFFF);
        vco_fall();
        check("applied kept", 32'(applied), 32'h5A3);
        check("cfg kept", {ref_div, pump, 8'h0}, 32'h0);
    endtask

    task automatic t_long();
        i_serial_host.send({12'h0, 4'hF, 4'h5, 12'h123}, 20, 1'b0);
        check("ref", 32'(ref_div), 32'h123);
        wr(4'h6, 12'h456);
        check("pump", 32'(pump), 32'h456);
    endtask

    task automatic t_mod_pin();
        wr(4'h8, 12'h005);
        i_serial_host.send(32'h6, 4, 1'b1);
        vco_fall();
        check("mod pin", 32'(applied), 32'h006);
        check("offset", {4'h0, offset}, exp_ofs(12'h006, 2));
    endtask

    task automatic t_main_10bit();
        wr(4'h7, 12'h000);
        wr(4'h1, 12'h334);
        check("main 10bit", 32'(main_ratio), {5'h0, 9'h00D, 18'h3FF34});
    endtask

    task automatic t_int();
        wr(4'h7, 12'hC00);
        wr(4'h0, 12'h020);
        check("main int", 32'(main_ratio), {5'h0, 9'h020, 18'h0});
        wr(4'h3, 12'h011);
        check("aux int", 32'(aux_ratio), {5'h0, 9'h011, 18'h0});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b     = 1'b0;
        vco       = 1'b1;
        exp_dvd   = 18'h0;
        fails     = 0;
        tests_run = 0;
        cycles    = 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_main_frac();
        t_aux_frac();
        t_addr_mod();
        t_short();
        t_refuse();
        t_long();
        t_mod_pin();
        t_main_10bit();
        t_int();
        give_verdict();
    end
endmodule
